// *** rtl/fmlm_pkg.sv ***
package fmlm_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int LAMP_ON_DLY_MS = 2500;
   localparam int LAMP_ON_DLY_CYC = (CLK_HZ / 1000) * LAMP_ON_DLY_MS;
   localparam int KEY_TEST_MS = 4000;
   localparam int KEY_TEST_CYC = (CLK_HZ / 1000) * KEY_TEST_MS;
   localparam int RECOG_US = 100;
   localparam int RECOG_CYC = (CLK_HZ / 1_000_000) * RECOG_US;
   localparam int K_BAUD = 10400;
   localparam int K_BIT_CYC = CLK_HZ / K_BAUD;
   localparam int NCH = 5;
   localparam int CH_IDLE_ACT = 0;
   localparam int CH_COOLANT = 1;
   localparam int CH_THROTTLE = 2;
   localparam int CH_AIR_TEMP = 3;
   localparam int CH_KNOCK = 4;
   localparam int FW = 4;
   localparam logic [FW-1:0] FREQ_INIT = 4'ha;
   localparam logic [FW-1:0] FREQ_LAST = 4'h1;
   localparam logic [FW-1:0] FREQ_ZERO = 4'h0;
   localparam int AXI_AW = 8;
   localparam int REG_STRIDE = 4;
   localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AXI_AW-1:0] REG_IMP = 8'h04;
   localparam logic [AXI_AW-1:0] REG_STAT = 8'h08;
   localparam logic [AXI_AW-1:0] REG_ACT = 8'h0c;
   localparam logic [AXI_AW-1:0] REG_RECOV_BASE = 8'h10;
   localparam logic [AXI_AW-1:0] REG_ENTRY_BASE = 8'h30;
   localparam int CTRL_CLR_BIT = 0;
   localparam int STAT_PRES_LSB = 0;
   localparam int STAT_PERM_LSB = 8;
   localparam int STAT_VALID_LSB = 16;
   localparam int STAT_LAMP_BIT = 24;
   localparam int STAT_KTEST_BIT = 25;
   localparam int ENT_FREQ_LSB = 0;
   localparam int ENT_VALID_BIT = 4;
   localparam int ENT_PERM_BIT = 5;
   localparam int ENT_STAMP_LSB = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] CMD_READ_ERR = 8'h01;
   localparam logic [7:0] CMD_READ_PARAM = 8'h02;
   localparam logic [7:0] CMD_ACT_TEST = 8'h03;
   localparam logic [7:0] CMD_CLEAR = 8'h04;
   localparam logic [7:0] RSP_ACK = 8'h06;
   localparam logic [7:0] RSP_NAK = 8'h15;
   localparam logic [3:0] K_LAST_RX_BIT = 4'h9;
   localparam logic [3:0] K_LAST_TX_BIT = 4'h9;
   typedef enum {K_IDLE, K_RX, K_EXEC, K_TX} fmlm_kst_e;
endpackage : fmlm_pkg

// *** rtl/fmlm_top.sv ***
`timescale 1ns/1ps
module fmlm_top import fmlm_pkg::*; #(
   parameter int DW = 8,
   parameter int RECOG = RECOG_CYC,
   parameter int LAMP_DLY = LAMP_ON_DLY_CYC,
   parameter int KEY_TEST = KEY_TEST_CYC,
   parameter int KBIT = K_BIT_CYC
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [AXI_AW-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [NCH-1:0] fault_raw_i,
   input wire logic [NCH*DW-1:0] sensor_val_i,
   output logic [NCH*DW-1:0] used_val_o,
   output logic [NCH-1:0] subst_o,
   input wire logic key_run_position_i,
   input wire logic engine_start_i,
   output logic lamp_on_o,
   output logic [7:0] act_test_o,
   input wire logic kline_i,
   output logic kline_o,
   output logic kline_oe_o
);
   localparam int CW = $clog2(NCH);
   localparam int RW = $clog2(RECOG + 1);
   localparam int LW = $clog2(LAMP_DLY + 1);
   localparam int TW = $clog2(KEY_TEST + 1);
   localparam int KW = $clog2(KBIT + 1);

   logic [RW-1:0] rcnt [NCH];
   logic [NCH-1:0] present, present_q, rise, fall, valid, perm, imp_mask;
   logic [FW-1:0] freq [NCH];
   logic [7:0] stamp [NCH];
   logic [DW-1:0] recov [NCH];
   logic [7:0] seq;
   logic clr_all, sw_clr, k_clr;
   logic start_m, start_s, start_d, start_p;
   logic key_m, key_s, key_d, key_rise, ktest, key_end, lit, qual;
   logic [TW-1:0] kcnt;
   logic [LW-1:0] ldly;
   logic kl_m, kl_s, kl_d;
   fmlm_kst_e kst;
   logic [KW-1:0] kcyc;
   logic [3:0] bitn;
   logic [7:0] rx_sh, rx_cmd, rx_arg, rsp_byte;
   logic [9:0] tx_sh;
   logic have_cmd, ch_ok;
   logic [CW-1:0] ai;
   logic aw_hold, w_hold, do_wr, wr_ok, rd_ok;
   logic [AXI_AW-1:0] aw_addr;
   logic [31:0] w_data, rd_word;
   logic [3:0] w_strb;

   // Pin synchronisers
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         {start_m, start_s, start_d} <= 3'h0;
         {key_m, key_s, key_d} <= 3'h0;
         {kl_m, kl_s, kl_d} <= 3'h7;
      end else begin
         {start_m, start_s, start_d} <= {engine_start_i, start_m, start_s};
         {key_m, key_s, key_d} <= {key_run_position_i, key_m, key_s};
         {kl_m, kl_s, kl_d} <= {kline_i, kl_m, kl_s};
      end
   end
   assign start_p = start_s & ~start_d;
   assign key_rise = key_s & ~key_d;

   // Recognition time filter per channel
   always_ff @(posedge core_clk_i) begin
      for (int c = 0; c < NCH; c++) begin
         if (srst_i || !fault_raw_i[c]) begin
            rcnt[c] <= '0;
            present[c] <= 1'b0;
         end else if (rcnt[c] == RW'(RECOG - 1)) begin
            present[c] <= 1'b1;
         end else begin
            rcnt[c] <= rcnt[c] + RW'(1);
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         present_q <= '0;
      end else begin
         present_q <= present;
      end
   end
   assign rise = present & ~present_q;
   assign fall = ~present & present_q;
   assign clr_all = sw_clr | k_clr;

   // Error memory records, a new detection wins over a clear
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         valid <= '0;
         perm <= '0;
         for (int c = 0; c < NCH; c++) begin
            freq[c] <= FREQ_ZERO;
            stamp[c] <= 8'h00;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (rise[c]) begin
               valid[c] <= 1'b1;
               perm[c] <= 1'b1;
               if (!valid[c] || clr_all) begin
                  freq[c] <= FREQ_INIT;
                  stamp[c] <= seq;
               end else if (freq[c] < FREQ_INIT) begin
                  freq[c] <= FREQ_INIT;
               end
            end else if (clr_all) begin
               valid[c] <= 1'b0;
               perm[c] <= 1'b0;
               freq[c] <= FREQ_ZERO;
            end else if (fall[c] && valid[c]) begin
               perm[c] <= 1'b0;
            end else if (start_p && valid[c] && !perm[c] && !present[c]) begin
               if (freq[c] <= FREQ_LAST) begin
                  valid[c] <= 1'b0;
                  freq[c] <= FREQ_ZERO;
               end else begin
                  freq[c] <= freq[c] - FREQ_LAST;
               end
            end
         end
      end
   end

   // Occurrence order stamp
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         seq <= 8'h00;
      end else if (|(rise & (~valid | {NCH{clr_all}}))) begin
         seq <= seq + 8'h01;
      end
   end

   // Recovery substitution for sensors and actuators
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         used_val_o <= '0;
         subst_o <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            used_val_o[c*DW +: DW] <= perm[c] ? recov[c] : sensor_val_i[c*DW +: DW];
         end
         subst_o <= perm;
      end
   end

   // Key-run lamp proof window
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ktest <= 1'b0;
         kcnt <= '0;
      end else if (key_rise) begin
         ktest <= 1'b1;
         kcnt <= '0;
      end else if (key_end) begin
         ktest <= 1'b0;
      end else if (ktest) begin
         kcnt <= kcnt + TW'(1);
      end
   end
   assign key_end = ktest && (kcnt == TW'(KEY_TEST - 1));

   // Lamp delay for important present faults
   assign qual = |(present & valid & imp_mask);
   always_ff @(posedge core_clk_i) begin
      if (srst_i || !qual) begin
         ldly <= '0;
         lit <= 1'b0;
      end else if (!lit) begin
         if (ldly == LW'(LAMP_DLY - 1) || key_end) begin
            lit <= 1'b1;
         end else begin
            ldly <= ldly + LW'(1);
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         lamp_on_o <= 1'b0;
      end else begin
         lamp_on_o <= ktest | (qual & lit);
      end
   end

   // Tester line: command byte, argument byte, one reply byte
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         kst <= K_IDLE;
         kcyc <= '0;
         bitn <= 4'h0;
         rx_sh <= 8'h00;
         rx_cmd <= 8'h00;
         rx_arg <= 8'h00;
         have_cmd <= 1'b0;
         tx_sh <= '1;
      end else begin
         case (kst)
            K_IDLE: begin
               if (kl_d && !kl_s) begin
                  kst <= K_RX;
                  kcyc <= KW'(KBIT / 2);
                  bitn <= 4'h0;
               end
            end
            K_RX: begin
               if (kcyc != '0) begin
                  kcyc <= kcyc - KW'(1);
               end else begin
                  kcyc <= KW'(KBIT - 1);
                  bitn <= bitn + 4'h1;
                  if (bitn == 4'h0 && kl_s) begin
                     kst <= K_IDLE;
                  end else if (bitn == K_LAST_RX_BIT) begin
                     have_cmd <= !have_cmd;
                     if (!have_cmd) begin
                        rx_cmd <= rx_sh;
                        kst <= K_IDLE;
                     end else begin
                        rx_arg <= rx_sh;
                        kst <= K_EXEC;
                     end
                  end else begin
                     rx_sh <= {kl_s, rx_sh[7:1]};
                  end
               end
            end
            K_EXEC: begin
               tx_sh <= {1'b1, rsp_byte, 1'b0};
               kcyc <= KW'(KBIT - 1);
               bitn <= 4'h0;
               kst <= K_TX;
            end
            K_TX: begin
               if (kcyc != '0) begin
                  kcyc <= kcyc - KW'(1);
               end else begin
                  kcyc <= KW'(KBIT - 1);
                  bitn <= bitn + 4'h1;
                  tx_sh <= {1'b1, tx_sh[9:1]};
                  if (bitn == K_LAST_TX_BIT) begin
                     kst <= K_IDLE;
                  end
               end
            end
            default: kst <= K_IDLE;
         endcase
      end
   end

   assign ai = rx_arg[CW-1:0];
   assign ch_ok = (rx_arg < 8'(NCH));
   always_comb begin
      rsp_byte = RSP_NAK;
      case (rx_cmd)
         CMD_READ_ERR: if (ch_ok) rsp_byte = {valid[ai], perm[ai], present[ai], 1'b0, freq[ai]};
         CMD_READ_PARAM: if (ch_ok) rsp_byte = 8'(used_val_o[ai*DW +: DW]);
         CMD_ACT_TEST: rsp_byte = RSP_ACK;
         CMD_CLEAR: rsp_byte = RSP_ACK;
         default: rsp_byte = RSP_NAK;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         k_clr <= 1'b0;
         kline_oe_o <= 1'b0;
      end else begin
         k_clr <= (kst == K_EXEC) && (rx_cmd == CMD_CLEAR);
         kline_oe_o <= (kst == K_TX) && !tx_sh[0];
      end
   end
   assign kline_o = 1'b0;

   // AXI4-Lite write channel
   assign s_axi_awready_o = !aw_hold;
   assign s_axi_wready_o = !w_hold;
   assign do_wr = aw_hold && w_hold && !s_axi_bvalid_o;
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid_i && !aw_hold) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && !w_hold) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
         end
         if (do_wr) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
         end
      end
   end

   always_comb begin
      wr_ok = (aw_addr == REG_CTRL) || (aw_addr == REG_IMP) || (aw_addr == REG_ACT);
      for (int c = 0; c < NCH; c++) begin
         if (aw_addr == REG_RECOV_BASE + AXI_AW'(REG_STRIDE * c)) wr_ok = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // Software registers and actuator test selection
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sw_clr <= 1'b0;
         imp_mask <= '0;
         act_test_o <= 8'h00;
         for (int c = 0; c < NCH; c++) recov[c] <= '0;
      end else begin
         sw_clr <= do_wr && w_strb[0] && (aw_addr == REG_CTRL) && w_data[CTRL_CLR_BIT];
         if (do_wr && w_strb[0] && aw_addr == REG_IMP) imp_mask <= w_data[NCH-1:0];
         if (do_wr && w_strb[0] && aw_addr == REG_ACT) begin
            act_test_o <= w_data[7:0];
         end else if (kst == K_EXEC && rx_cmd == CMD_ACT_TEST) begin
            act_test_o <= rx_arg;
         end
         for (int c = 0; c < NCH; c++) begin
            if (do_wr && w_strb[0] && aw_addr == REG_RECOV_BASE + AXI_AW'(REG_STRIDE * c)) begin
               recov[c] <= w_data[DW-1:0];
            end
         end
      end
   end

   // AXI4-Lite read channel
   assign s_axi_arready_o = !s_axi_rvalid_o;
   always_comb begin
      rd_word = 32'h0;
      rd_ok = 1'b1;
      if (s_axi_araddr_i == REG_CTRL) begin
         rd_word = 32'h0;
      end else if (s_axi_araddr_i == REG_IMP) begin
         rd_word[NCH-1:0] = imp_mask;
      end else if (s_axi_araddr_i == REG_STAT) begin
         rd_word[STAT_PRES_LSB +: NCH] = present;
         rd_word[STAT_PERM_LSB +: NCH] = perm;
         rd_word[STAT_VALID_LSB +: NCH] = valid;
         rd_word[STAT_LAMP_BIT] = lamp_on_o;
         rd_word[STAT_KTEST_BIT] = ktest;
      end else if (s_axi_araddr_i == REG_ACT) begin
         rd_word[7:0] = act_test_o;
      end else begin
         rd_ok = 1'b0;
      end
      for (int c = 0; c < NCH; c++) begin
         if (s_axi_araddr_i == REG_RECOV_BASE + AXI_AW'(REG_STRIDE * c)) begin
            rd_word[DW-1:0] = recov[c];
            rd_ok = 1'b1;
         end
         if (s_axi_araddr_i == REG_ENTRY_BASE + AXI_AW'(REG_STRIDE * c)) begin
            rd_word[ENT_FREQ_LSB +: FW] = freq[c];
            rd_word[ENT_VALID_BIT] = valid[c];
            rd_word[ENT_PERM_BIT] = perm[c];
            rd_word[ENT_STAMP_LSB +: 8] = stamp[c];
            rd_ok = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0;
         s_axi_rresp_o <= RESP_OKAY;
      end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_word;
         s_axi_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   sequence s_key_proof;
      key_rise ##1 ktest;
   endsequence

   for (genvar g = 0; g < NCH; g++) begin : g_chk
      a_first_perm: assert property (rise[g] && !valid[g] |=> valid[g] && perm[g] && freq[g] == FREQ_INIT)
         else $error("first detection not stored permanent with count ten");
      a_to_intermit: assert property (fall[g] && valid[g] && !clr_all |=> !perm[g] && valid[g])
         else $error("vanished fault not made intermittent");
      a_recov_sel: assert property (perm[g] |=> used_val_o[g*DW +: DW] == $past(recov[g]))
         else $error("recovery value not applied");
      a_recur_count: assert property (rise[g] && valid[g] && !clr_all |=> freq[g] >= FREQ_INIT && perm[g])
         else $error("recurring fault count not restored");
      a_age_step: assert property (start_p && valid[g] && !perm[g] && !present[g] && !rise[g] && !clr_all
         && freq[g] > FREQ_LAST |=> freq[g] == $past(freq[g]) - FREQ_LAST && valid[g])
         else $error("intermittent count not decremented by one");
      a_age_delete: assert property (start_p && valid[g] && !perm[g] && !present[g] && !rise[g]
         && freq[g] <= FREQ_LAST |=> !valid[g] && freq[g] == FREQ_ZERO)
         else $error("expired fault not deleted");
   end

   a_clear_all: assert property (clr_all && !(|rise) |=> valid == '0 && perm == '0)
      else $error("clear did not erase memory");
   a_lamp_cause: assert property (lamp_on_o && !$past(ktest) |-> $past(qual))
      else $error("lamp lit without important present fault");
   a_lamp_off: assert property ($fell(qual) && !ktest |=> !lamp_on_o)
      else $error("lamp not dark after fault left");
   a_lamp_proof: assert property (s_key_proof |=> lamp_on_o)
      else $error("key run proof lamp missing");
endmodule : fmlm_top

// *** tb/fmlm_tester.sv ***
`timescale 1ns/1ps
module fmlm_tester #(
   parameter int KBIT = 8
) (
   input wire logic clk_i,
   input wire logic line_i,
   output logic pull_o,
   output logic [7:0] rx_o,
   output logic rx_v_o
);
   initial begin
      pull_o = 1'b0;
      rx_o = 8'h00;
      rx_v_o = 1'b0;
   end
   // One 8N1 frame on the shared line, LSB first
   task send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         pull_o <= !f[i];
         repeat (KBIT) @(posedge clk_i);
      end
   endtask : send
   // Command and argument, then the reply frame
   task xfer(input logic [7:0] c, input logic [7:0] a);
      int n;
      send(c);
      send(a);
      n = 0;
      while (line_i && n < 40 * KBIT) begin
         @(posedge clk_i);
         n++;
      end
      repeat (KBIT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (KBIT) @(posedge clk_i);
         rx_o[i] <= line_i;
      end
      repeat (KBIT) @(posedge clk_i);
      rx_v_o <= 1'b1;
      @(posedge clk_i);
      rx_v_o <= 1'b0;
      repeat (KBIT) @(posedge clk_i);
   endtask : xfer
endmodule : fmlm_tester

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import fmlm_pkg::*;
   logic clk, srst, awv, awr, wv, wrdy, bv, bready, arv, arr, rv, rready, key, start, lamp, koe, kout, pull, rxv;
   logic [7:0] aw, ar, act, rxb, r8;
   logic [31:0] wd, rdat;
   logic [1:0] bresp, rresp;
   logic [3:0] strb;
   logic [1:0] bq[$];
   logic [4:0] fault, subst;
   logic [39:0] sens, used;
   logic [65:0] rq[$];
   logic [7:0] kq[$];
   int mismatches, compares;
   wire line = !(koe | pull);
   fmlm_top #(.RECOG(4), .LAMP_DLY(20), .KEY_TEST(30), .KBIT(8)) fmlm_top_i (
      .core_clk_i(clk), .srst_i(srst), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready), .s_axi_araddr_i(ar),
      .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rready), .fault_raw_i(fault), .sensor_val_i(sens),
      .used_val_o(used), .subst_o(subst), .key_run_position_i(key), .engine_start_i(start),
      .lamp_on_o(lamp), .act_test_o(act), .kline_i(line), .kline_o(kout), .kline_oe_o(koe));
   fmlm_tester #(.KBIT(8)) fmlm_tester_i (.clk_i(clk), .line_i(line), .pull_o(pull), .rx_o(rxb), .rx_v_o(rxv));
   initial begin
      clk = 1'b0;
      forever #25 clk = !clk;
   end
   task chk(input logic [33:0] s, input logic [33:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, s, e);
      end
   endtask : chk
   task close_out;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bq.push_back(r);
      @(posedge clk);
      aw <= a;
      awv <= 1'b1;
      wd <= d;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
         if (bready && bv) bready <= 1'b0;
      end while (awv || wv || bready);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [1:0] r, input logic [31:0] e);
      rq.push_back({r, m, e});
      @(posedge clk);
      ar <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
         if (rready && rv) rready <= 1'b0;
      end while (arv || rready);
   endtask : rd
   task starts(input int n);
      repeat (n) begin
         start <= 1'b1;
         cyc(3);
         start <= 1'b0;
         cyc(6);
      end
   endtask : starts
   task kx(input logic [7:0] c, input logic [7:0] a, input logic [7:0] e);
      kq.push_back(e);
      fmlm_tester_i.xfer(c, a);
   endtask : kx
   always @(posedge clk) begin
      logic [65:0] q;
      if (rv && rready) begin
         q = rq.pop_front();
         chk({rresp, rdat & q[63:32]}, {q[65:64], q[31:0]});
      end
      if (rxv)
         chk({26'h0, rxb}, {26'h0, kq.pop_front()});
      if (bv && bready)
         chk({32'h0, bresp}, {32'h0, bq.pop_front()});
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out();
   end
   initial begin
      {srst, awv, wv, bready, arv, rready, key, start} = 8'hff;
      {awv, wv, bready, arv, rready, key, start} = 7'h00;
      {aw, ar, wd, fault} = 53'h0;
      strb = 4'hf;
      void'($urandom(21898));
      sens = {8'($urandom), 32'($urandom)};
      r8 = 8'($urandom);
      cyc(12);
      srst <= 1'b0;
      wr(REG_RECOV_BASE + 8'h04, {24'h0, r8}, RESP_OKAY);
      wr(REG_IMP, 32'h2, RESP_OKAY);
      rd(8'h02, 32'h0, RESP_SLVERR, 32'h0);
      rd(REG_RECOV_BASE + 8'h04, 32'hff, RESP_OKAY, {24'h0, r8});
      strb <= 4'h0;
      wr(REG_IMP, 32'h1f, RESP_OKAY);
      strb <= 4'hf;
      wr(REG_STAT, 32'hffffffff, RESP_SLVERR);
      rd(REG_IMP, 32'h1f, RESP_OKAY, 32'h2);
      fault <= 5'h02;
      cyc(10);
      chk({33'h0, subst[1]}, 34'h1);
      chk({26'h0, used[15:8]}, {26'h0, r8});
      chk({33'h0, lamp}, 34'h0);
      rd(REG_ENTRY_BASE + 8'h04, 32'h3f, RESP_OKAY, 32'h3a);
      cyc(14);
      chk({33'h0, lamp}, 34'h1);
      fault <= 5'h00;
      cyc(5);
      chk({33'h0, lamp}, 34'h0);
      chk({26'h0, used[15:8]}, {26'h0, sens[15:8]});
      rd(REG_ENTRY_BASE + 8'h04, 32'h3f, RESP_OKAY, 32'h1a);
      starts(3);
      rd(REG_ENTRY_BASE + 8'h04, 32'h3f, RESP_OKAY, 32'h17);
      fault <= 5'h02;
      cyc(10);
      rd(REG_ENTRY_BASE + 8'h04, 32'h3f, RESP_OKAY, 32'h3a);
      fault <= 5'h00;
      cyc(5);
      starts(11);
      rd(REG_ENTRY_BASE + 8'h04, 32'h1f, RESP_OKAY, 32'h0);
      r8 = 8'($urandom);
      wr(REG_RECOV_BASE + 8'h08, {24'h0, r8}, RESP_OKAY);
      fault <= 5'h04;
      cyc(10);
      chk({33'h0, subst[2]}, 34'h1);
      kx(CMD_READ_ERR, 8'h02, 8'hea);
      kx(CMD_READ_PARAM, 8'h02, r8);
      r8 = 8'($urandom);
      kx(CMD_ACT_TEST, r8, RSP_ACK);
      chk({26'h0, act}, {26'h0, r8});
      chk({33'h0, kout}, 34'h0);
      kx(CMD_READ_ERR, 8'h05, RSP_NAK);
      kx(8'h00, 8'h00, RSP_NAK);
      kx(CMD_CLEAR, 8'h00, RSP_ACK);
      cyc(4);
      rd(REG_STAT, 32'h1f0000, RESP_OKAY, 32'h0);
      fault <= 5'h00;
      cyc(5);
      key <= 1'b1;
      cyc(8);
      chk({33'h0, lamp}, 34'h1);
      cyc(40);
      chk({33'h0, lamp}, 34'h0);
      close_out();
   end
endmodule : tb_top
